// File: design/usb_setup_regs.svh
// Register indices, field positions, reset values and limits of the block
`ifndef USB_SETUP_REGS_SVH
`define USB_SETUP_REGS_SVH

// Register indices; byte address is four times the index
`define REQ_CODE_TYPE_IDX 8'h78
`define REQ_VALUE_IDX 8'h7A
`define REQ_INDEX_IDX 8'h7C
`define REQ_LENGTH_IDX 8'h7E
`define PIPE_MODE_CFG_IDX 8'h82
`define PIPE_LIMITS_IDX 8'h86
`define PIPE_STATUS_IDX 8'h87

`define CAPTURE_RESET 16'h0000
`define PIPE_MODE_CFG_RESET 16'h0000
`define CONT_MODE_BIT 8
`define MPS_LSB 0
`define MPS_MSB 6
`define TX_LEN_LSB 16
`define TX_LEN_MSB 24
`define MPS_RESET 7'h40
`define TX_LEN_RESET 9'h000
`define PIPE_BUFFER_BYTES 10'h100

`endif

// File: design/usb_setup_pkg.sv
// Types shared by the setup capture and control pipe block
package usb_setup_pkg;
    typedef enum logic [1:0] {
        STAGE_IDLE = 2'b00,
        STAGE_FILL = 2'b01,
        STAGE_SEND = 2'b11
    } tx_stage_e;
    typedef logic [15:0] half_word_t;
endpackage

// File: design/usb_setup_capture.sv
// Setup packet capture registers and control pipe data-stage completion
`timescale 1ns/1ps
`include "usb_setup_regs.svh"

module usb_setup_capture #(
    parameter int PADDR_W = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pclk_en,
    input wire logic soft_reset,
    input wire logic bus_reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic setup_valid,
    input wire logic [63:0] setup_data,
    input wire logic fill_byte,
    input wire logic buffer_valid_flag_wr,
    input wire logic tx_byte,
    input wire logic tx_short_sent,
    input wire logic rx_pkt_done,
    input wire logic [7:0] rx_pkt_len,
    output logic buffer_valid_flag,
    output logic continuous_transfer_select,
    output logic fill_done,
    output logic tx_done,
    output logic rx_done
);

    function automatic logic [PADDR_W-1:0] byte_addr(input logic [7:0] idx);
        byte_addr = PADDR_W'({idx, 2'b00});
    endfunction

    function automatic logic hit(input logic [PADDR_W-1:0] a,
                                 input logic [7:0] idx);
        hit = (a == byte_addr(idx));
    endfunction

    usb_setup_pkg::half_word_t req0_r, req1_r, req2_r, req3_r;
    usb_setup_pkg::half_word_t req0_nxt, req1_nxt, req2_nxt, req3_nxt;
    logic cfg_mode_r, cfg_mode_nxt;
    logic [6:0] mps_r, mps_nxt;
    logic [8:0] tx_len_r, tx_len_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    usb_setup_pkg::tx_stage_e stage_r, stage_nxt;
    logic [8:0] fill_cnt_r, fill_cnt_nxt;
    logic [8:0] tx_cnt_r, tx_cnt_nxt;
    logic [8:0] rx_cnt_r, rx_cnt_nxt;
    logic buffer_valid_flag_r, buffer_valid_flag_nxt;

    logic access, wr_en, mapped;
    logic [8:0] limit;
    logic [9:0] rx_total;
    logic rx_short;

    // APB decode
    always_comb begin
        if (hit(paddr, `REQ_CODE_TYPE_IDX)) begin
            mapped = 1'b1;
        end else if (hit(paddr, `REQ_VALUE_IDX)) begin
            mapped = 1'b1;
        end else if (hit(paddr, `REQ_INDEX_IDX)) begin
            mapped = 1'b1;
        end else if (hit(paddr, `REQ_LENGTH_IDX)) begin
            mapped = 1'b1;
        end else if (hit(paddr, `PIPE_MODE_CFG_IDX)) begin
            mapped = 1'b1;
        end else if (hit(paddr, `PIPE_LIMITS_IDX)) begin
            mapped = 1'b1;
        end else if (hit(paddr, `PIPE_STATUS_IDX)) begin
            mapped = 1'b1;
        end else begin
            mapped = 1'b0;
        end
    end

    // Clock enable low stretches the access phase
    assign pready = pclk_en;
    assign access = psel && penable && pclk_en;
    assign pslverr = psel && penable && !mapped;
    assign wr_en = access && pwrite && mapped;
    assign prdata = prdata_r;

    // Read data latched during setup phase, shown in access phase
    always_comb begin
        prdata_nxt = prdata_r;
        if (psel && !penable && !pwrite) begin
            if (hit(paddr, `REQ_CODE_TYPE_IDX)) begin
                prdata_nxt = {16'h0000, req0_r};
            end else if (hit(paddr, `REQ_VALUE_IDX)) begin
                prdata_nxt = {16'h0000, req1_r};
            end else if (hit(paddr, `REQ_INDEX_IDX)) begin
                prdata_nxt = {16'h0000, req2_r};
            end else if (hit(paddr, `REQ_LENGTH_IDX)) begin
                prdata_nxt = {16'h0000, req3_r};
            end else if (hit(paddr, `PIPE_MODE_CFG_IDX)) begin
                prdata_nxt = 32'h0000_0000;
                prdata_nxt[`CONT_MODE_BIT] = cfg_mode_r;
            end else if (hit(paddr, `PIPE_LIMITS_IDX)) begin
                prdata_nxt = 32'h0000_0000;
                prdata_nxt[`MPS_MSB:`MPS_LSB] = mps_r;
                prdata_nxt[`TX_LEN_MSB:`TX_LEN_LSB] = tx_len_r;
            end else if (hit(paddr, `PIPE_STATUS_IDX)) begin
                prdata_nxt = {5'h00, rx_cnt_r, 5'h00, fill_cnt_r,
                              1'b0, stage_r, buffer_valid_flag_r};
            end else begin
                prdata_nxt = 32'h0000_0000;
            end
        end
    end

    // Setup capture: all four words load at once, writes ignored
    always_comb begin
        req0_nxt = req0_r;
        req1_nxt = req1_r;
        req2_nxt = req2_r;
        req3_nxt = req3_r;
        if (soft_reset || bus_reset) begin
            req0_nxt = `CAPTURE_RESET;
            req1_nxt = `CAPTURE_RESET;
            req2_nxt = `CAPTURE_RESET;
            req3_nxt = `CAPTURE_RESET;
        end else if (setup_valid) begin
            req0_nxt = {setup_data[15:8], setup_data[7:0]};
            req1_nxt = {setup_data[31:24], setup_data[23:16]};
            req2_nxt = {setup_data[47:40], setup_data[39:32]};
            req3_nxt = {setup_data[63:56], setup_data[55:48]};
        end
    end

    // Software configuration; bus reset leaves it alone
    always_comb begin
        cfg_mode_nxt = cfg_mode_r;
        mps_nxt = mps_r;
        tx_len_nxt = tx_len_r;
        if (soft_reset) begin
            cfg_mode_nxt = 1'b0;
            mps_nxt = `MPS_RESET;
            tx_len_nxt = `TX_LEN_RESET;
        end else if (wr_en && hit(paddr, `PIPE_MODE_CFG_IDX) && pstrb[1]) begin
            cfg_mode_nxt = pwdata[`CONT_MODE_BIT];
        end else if (wr_en && hit(paddr, `PIPE_LIMITS_IDX)) begin
            if (pstrb[0]) begin
                mps_nxt = pwdata[`MPS_MSB:`MPS_LSB];
            end
            if (pstrb[2] && pstrb[3]) begin
                tx_len_nxt = pwdata[`TX_LEN_MSB:`TX_LEN_LSB];
            end
        end
    end

    assign continuous_transfer_select = cfg_mode_r;
    // Fill and send end at max packet size or continuous length
    assign limit = cfg_mode_r ? tx_len_r : {2'b00, mps_r};

    // Control read: buffer fill then send
    always_comb begin
        stage_nxt = stage_r;
        fill_cnt_nxt = fill_cnt_r;
        tx_cnt_nxt = tx_cnt_r;
        buffer_valid_flag_nxt = buffer_valid_flag_r;
        fill_done = 1'b0;
        tx_done = 1'b0;
        if (soft_reset || setup_valid) begin
            stage_nxt = usb_setup_pkg::STAGE_IDLE;
            fill_cnt_nxt = 9'h000;
            tx_cnt_nxt = 9'h000;
            buffer_valid_flag_nxt = 1'b0;
        end else begin
            case (stage_r)
                usb_setup_pkg::STAGE_IDLE, usb_setup_pkg::STAGE_FILL: begin
                    if (buffer_valid_flag_wr) begin
                        fill_done = pclk_en;
                        buffer_valid_flag_nxt = 1'b1;
                        fill_cnt_nxt = 9'h000;
                        stage_nxt = usb_setup_pkg::STAGE_SEND;
                    end else if (fill_byte) begin
                        if (fill_cnt_r + 9'h001 >= limit) begin
                            fill_done = pclk_en;
                            buffer_valid_flag_nxt = 1'b1;
                            fill_cnt_nxt = 9'h000;
                            stage_nxt = usb_setup_pkg::STAGE_SEND;
                        end else begin
                            fill_cnt_nxt = fill_cnt_r + 9'h001;
                            stage_nxt = usb_setup_pkg::STAGE_FILL;
                        end
                    end
                end
                usb_setup_pkg::STAGE_SEND: begin
                    if (tx_short_sent ||
                        (tx_byte && tx_cnt_r + 9'h001 >= limit)) begin
                        tx_done = pclk_en;
                        buffer_valid_flag_nxt = 1'b0;
                        tx_cnt_nxt = 9'h000;
                        stage_nxt = usb_setup_pkg::STAGE_IDLE;
                    end else if (tx_byte) begin
                        tx_cnt_nxt = tx_cnt_r + 9'h001;
                    end
                end
                default: begin
                    stage_nxt = usb_setup_pkg::STAGE_IDLE;
                end
            endcase
        end
    end

    assign buffer_valid_flag = buffer_valid_flag_r;

    // Control write: receive completion
    assign rx_total = {1'b0, rx_cnt_r} + {2'b00, rx_pkt_len};
    assign rx_short = rx_pkt_len < {1'b0, mps_r};
    always_comb begin
        rx_cnt_nxt = rx_cnt_r;
        rx_done = 1'b0;
        if (soft_reset || setup_valid) begin
            rx_cnt_nxt = 9'h000;
        end else if (rx_pkt_done) begin
            if (!cfg_mode_r || rx_short ||
                rx_total >= `PIPE_BUFFER_BYTES) begin
                rx_done = pclk_en;
                rx_cnt_nxt = 9'h000;
            end else begin
                rx_cnt_nxt = rx_total[8:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req0_r <= `CAPTURE_RESET;
            req1_r <= `CAPTURE_RESET;
            req2_r <= `CAPTURE_RESET;
            req3_r <= `CAPTURE_RESET;
            cfg_mode_r <= 1'b0;
            mps_r <= `MPS_RESET;
            tx_len_r <= `TX_LEN_RESET;
            prdata_r <= 32'h0000_0000;
            stage_r <= usb_setup_pkg::STAGE_IDLE;
            fill_cnt_r <= 9'h000;
            tx_cnt_r <= 9'h000;
            rx_cnt_r <= 9'h000;
            buffer_valid_flag_r <= 1'b0;
        end else if (pclk_en) begin
            req0_r <= req0_nxt;
            req1_r <= req1_nxt;
            req2_r <= req2_nxt;
            req3_r <= req3_nxt;
            cfg_mode_r <= cfg_mode_nxt;
            mps_r <= mps_nxt;
            tx_len_r <= tx_len_nxt;
            prdata_r <= prdata_nxt;
            stage_r <= stage_nxt;
            fill_cnt_r <= fill_cnt_nxt;
            tx_cnt_r <= tx_cnt_nxt;
            rx_cnt_r <= rx_cnt_nxt;
            buffer_valid_flag_r <= buffer_valid_flag_nxt;
        end
    end

    capture_load_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        setup_valid && pclk_en && !soft_reset && !bus_reset |=>
            req0_r == {$past(setup_data[15:8]), $past(setup_data[7:0])} &&
            req3_r == $past(setup_data[63:48]))
        else $error("setup capture did not load");

    capture_clear_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        bus_reset && pclk_en |=>
            req0_r == 16'h0000 && req1_r == 16'h0000 &&
            req2_r == 16'h0000 && req3_r == 16'h0000)
        else $error("bus reset left capture set");

    capture_ro_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_en && !setup_valid && !soft_reset && !bus_reset |=>
            $stable(req1_r) && $stable(req2_r))
        else $error("write changed capture register");

    cfg_keep_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        bus_reset && pclk_en && !soft_reset && !wr_en |=> $stable(cfg_mode_r))
        else $error("bus reset changed pipe mode");

    cfg_soft_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        soft_reset && pclk_en |=> !cfg_mode_r)
        else $error("soft reset kept pipe mode");

    rx_single_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        pclk_en && rx_pkt_done && !cfg_mode_r && !soft_reset && !setup_valid
            |-> rx_done)
        else $error("per-packet receive not ended");

    rx_cont_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        rx_pkt_done && cfg_mode_r && !rx_short && rx_total < 10'h100
            |-> !rx_done)
        else $error("continuous receive ended early");

    fill_auto_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        fill_done && !soft_reset |=>
            buffer_valid_flag_r && stage_r == usb_setup_pkg::STAGE_SEND)
        else $error("buffer valid not set on fill end");

    tx_end_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        tx_done |=> !buffer_valid_flag_r ##1 !tx_done)
        else $error("send end did not release buffer");

endmodule

// File: dv/usb_host_model.sv
// Host-side model: setup packets, IN data bytes and OUT packets
`timescale 1ns/1ps
module usb_host_model (
    input wire logic pclk,
    input wire logic tx_done,
    input wire logic rx_done,
    output logic setup_valid,
    output logic [63:0] setup_data,
    output logic tx_byte,
    output logic tx_short_sent,
    output logic rx_pkt_done,
    output logic [7:0] rx_pkt_len
);
    initial begin
        setup_valid = 1'b0;
        setup_data = 64'h0;
        tx_byte = 1'b0;
        tx_short_sent = 1'b0;
        rx_pkt_done = 1'b0;
        rx_pkt_len = 8'h00;
    end
    // Whole packet in one beat; lines scrambled once released
    task send_setup(input logic [63:0] d);
        @(posedge pclk);
        setup_valid <= 1'b1;
        setup_data <= d;
        @(posedge pclk);
        setup_valid <= 1'b0;
        setup_data <= ~d;
    endtask
    // Pulls n bytes, optional short end; gap makes a slow host
    task take(input int n, input int gap, input logic sh, output int at);
        at = -1;
        for (int i = 0; i < n; i++) begin
            @(posedge pclk);
            tx_byte <= 1'b1;
            @(negedge pclk);
            if (tx_done === 1'b1) at = i;
            if (gap > 0) begin
                @(posedge pclk);
                tx_byte <= 1'b0;
                repeat (gap - 1) @(posedge pclk);
            end
        end
        @(posedge pclk);
        tx_byte <= 1'b0;
        tx_short_sent <= sh;
        @(negedge pclk);
        if (sh && tx_done === 1'b1) at = n;
        @(posedge pclk);
        tx_short_sent <= 1'b0;
    endtask
    task give(input logic [7:0] len, output logic done);
        @(posedge pclk);
        rx_pkt_done <= 1'b1;
        rx_pkt_len <= len;
        @(negedge pclk);
        done = rx_done;
        @(posedge pclk);
        rx_pkt_done <= 1'b0;
        rx_pkt_len <= ~len;
    endtask
endmodule

// File: dv/tb_usb_setup_capture.sv
// Self-checking bench for setup capture and control pipe modes
`timescale 1ns/1ps
`include "usb_setup_regs.svh"
module tb_usb_setup_capture;
    logic pclk, presetn, soft_reset, bus_reset, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, st, seed, lim;
    logic pready, pslverr, setup_valid, tx_byte, tx_short_sent, rxd;
    logic fill_byte, buffer_valid_flag_wr, bvf, cts, fill_done, tx_done, rx_done;
    logic rx_pkt_done, pclk_en;
    logic [3:0] strb;
    logic [63:0] setup_data, sd;
    logic [7:0] rx_pkt_len;
    int mismatches, compares, at, mps, len, tot, waits;
    usb_setup_capture usb_setup_capture_inst (.pclk(pclk),
        .presetn(presetn), .pclk_en(pclk_en), .soft_reset(soft_reset),
        .bus_reset(bus_reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(strb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .setup_valid(setup_valid), .setup_data(setup_data),
        .fill_byte(fill_byte), .buffer_valid_flag_wr(buffer_valid_flag_wr), .tx_byte(tx_byte),
        .tx_short_sent(tx_short_sent), .rx_pkt_done(rx_pkt_done),
        .rx_pkt_len(rx_pkt_len), .buffer_valid_flag(bvf),
        .continuous_transfer_select(cts), .fill_done(fill_done),
        .tx_done(tx_done), .rx_done(rx_done));
    usb_host_model usb_host_model_inst (.pclk(pclk), .tx_done(tx_done),
        .rx_done(rx_done), .setup_valid(setup_valid),
        .setup_data(setup_data), .tx_byte(tx_byte),
        .tx_short_sent(tx_short_sent), .rx_pkt_done(rx_pkt_done),
        .rx_pkt_len(rx_pkt_len));
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task check(input string nm, input logic [31:0] seen, input logic [31:0] e);
        compares++;
        if (seen !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, e, seen);
        end
    endtask
    task conclude;
        if (mismatches == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) mismatches++;
        waits = n;
        rd = prdata;
        st = {31'h0, pslverr};
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task fill(input int n, input logic bv, output int a);
        a = -1;
        for (int i = 0; i < n; i++) begin
            @(posedge pclk);
            fill_byte <= 1'b1;
            @(negedge pclk);
            if (fill_done === 1'b1) a = i;
        end
        @(posedge pclk);
        fill_byte <= 1'b0;
        buffer_valid_flag_wr <= bv;
        @(negedge pclk);
        if (bv && fill_done === 1'b1) a = n;
        @(posedge pclk);
        buffer_valid_flag_wr <= 1'b0;
    endtask
    task pulse_rst(input logic bus);
        @(posedge pclk);
        bus_reset <= bus;
        soft_reset <= !bus;
        @(posedge pclk);
        bus_reset <= 1'b0;
        soft_reset <= 1'b0;
    endtask
    // Captures read back as sent; writes to them are ignored
    task caps(input logic [63:0] d);
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, `REQ_CODE_TYPE_IDX + 8'(2 * k), xs(d[31:0]));
            apb(1'b0, `REQ_CODE_TYPE_IDX + 8'(2 * k), 32'h0);
            check("capture", rd, {16'h0, d[16 * k +: 16]});
        end
    endtask
    initial begin
        {presetn, soft_reset, bus_reset, psel, penable, pwrite} = 6'h00;
        {fill_byte, buffer_valid_flag_wr, paddr, pwdata} = 46'h0;
        pclk_en = 1'b1;
        strb = 4'hF;
        mismatches = 0;
        compares = 0;
        seed = 32'h00000027;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        caps(64'h0);
        apb(1'b0, `PIPE_MODE_CFG_IDX, 32'h0);
        check("mode", rd, 32'h0);
        apb(1'b0, `PIPE_LIMITS_IDX, 32'h0);
        check("limits", rd, 32'h00000040);
        apb(1'b0, 8'h01, 32'h0);
        check("slverr", st, 32'h1);
        for (int i = 0; i < 6; i++) begin
            seed = xs(seed);
            sd[31:0] = seed;
            seed = xs(seed);
            sd[63:32] = (i == 0) ? 32'hFFFFFFFF : seed;
            usb_host_model_inst.send_setup(sd);
            caps(sd);
        end
        // Enable low: access stretched, setup pulse ignored
        fork
            apb(1'b0, `PIPE_MODE_CFG_IDX, 32'h0);
            begin
                repeat (2) @(posedge pclk);
                pclk_en <= 1'b0;
                usb_host_model_inst.send_setup(~sd);
                @(posedge pclk);
                pclk_en <= 1'b1;
            end
        join
        check("mode frozen", rd, 32'h0);
        check("wait states", 32'(waits), 32'h4);
        caps(sd);
        apb(1'b1, `PIPE_MODE_CFG_IDX, 32'h0000FFFF);
        @(negedge pclk);
        check("mode bit", {31'h0, cts}, 32'h1);
        pulse_rst(1'b1);
        caps(64'h0);
        apb(1'b0, `PIPE_MODE_CFG_IDX, 32'h0);
        check("mode kept", rd, 32'h00000100);
        usb_host_model_inst.send_setup(sd);
        pulse_rst(1'b0);
        caps(64'h0);
        apb(1'b0, `PIPE_MODE_CFG_IDX, 32'h0);
        check("mode clear", rd, 32'h0);
        // Mode byte lane strobe low: write ignored
        strb <= 4'hD;
        apb(1'b1, `PIPE_MODE_CFG_IDX, 32'h00000100);
        strb <= 4'hF;
        apb(1'b0, `PIPE_MODE_CFG_IDX, 32'h0);
        check("mode strobe", rd, 32'h0);
        for (int m = 0; m < 2; m++) begin
            seed = xs(seed);
            mps = 8 << (seed % 4);
            len = 8 + int'(seed[15:8] % 40);
            lim = m ? len : mps;
            apb(1'b1, `PIPE_LIMITS_IDX, {7'h0, 9'(len), 9'h0, 7'(mps)});
            apb(1'b1, `PIPE_MODE_CFG_IDX, {23'h0, 1'(m), 8'h0});
            fill(lim, 1'b0, at);
            check("fill end", 32'(at), lim - 1);
            check("buffer_valid_flag set", {31'h0, bvf}, 32'h1);
            usb_host_model_inst.take(lim, m * 2, 1'b0, at);
            @(negedge pclk);
            check("send end", 32'(at), lim - 1);
            check("buffer_valid_flag clr", {31'h0, bvf}, 32'h0);
            fill(3, 1'b1, at);
            check("fill short", 32'(at), 32'h3);
            usb_host_model_inst.take(3, 0, 1'b1, at);
            check("send short", 32'(at), 32'h3);
            tot = 0;
            while (tot < 256) begin
                usb_host_model_inst.give(8'(mps), rxd);
                tot = m ? tot + mps : 256;
                check("rx full", {31'h0, rxd}, {31'h0, tot >= 256});
            end
            usb_host_model_inst.give(8'(seed[20:16] % mps), rxd);
            check("rx short", {31'h0, rxd}, 32'h1);
        end
        conclude();
    end
    initial begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        conclude();
    end
endmodule
